// ===== rtl/swc_cfg_regs.sv
// Global setup and hi-z register bank with wake, interrupt and poll control.
// Assumes analog front end consumes current enables; SPI link on its own clock.
`timescale 1ns/1ps
module swc_cfg_regs
  import swc_pkg::*;
#(
  parameter int unsigned POLL_LONG_CYC = SWC_POLL_LONG_CYC,
  parameter int unsigned POLL_SHORT_CYC = SWC_POLL_SHORT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic fault_summary,
  input wire logic irq_event,
  input wire logic battery_overvoltage,
  input wire logic sleep_mode,
  input wire logic logic_supply_rail,
  input wire logic wake_n,
  input wire logic [21:0] comp_above,
  output logic [21:0] closed_status,
  output logic [21:0] source_enable,
  output logic [7:0] switch_to_battery,
  output logic current_cap,
  output logic sleep_block,
  output logic ov_flag,
  output logic wake_req,
  output logic irq_n,
  output logic battery_channel_poll_select,
  output logic poll_active,
  output logic poll_end
);
  localparam int unsigned PCW = 18;
  localparam logic [PCW-1:0] PLONG = PCW'(POLL_LONG_CYC - 1);
  localparam logic [PCW-1:0] PSHORT = PCW'(POLL_SHORT_CYC - 1);
  localparam logic [4:0] IPULSE = 5'(SWC_IRQ_PULSE_CYC);

  typedef struct packed {
    logic [23:0] setup;
    logic [23:0] prog_hiz;
    logic [23:0] gnd_hiz;
    logic [2:0] tsync;
    logic [23:0] tx;
    logic [2:0] wsync;
    logic [1:0] rsync;
    logic [21:0] ref_state;
    logic [21:0] closed;
    logic [PCW-1:0] pcnt;
    logic pend;
    logic wake;
    logic irq_lat;
    logic [4:0] icnt;
    logic ov;
  } swc_st_t;
  swc_st_t q, d;

  logic [31:0] rx_word;
  logic rx_tgl;
  logic frame_ev;
  logic [6:0] f_addr;
  logic f_wr;
  logic [23:0] f_data;
  logic [23:0] rd_data;
  logic wake_fall;
  logic wake_ok;
  logic [PCW-1:0] plen;
  logic [21:0] hiz;
  logic [21:0] sw_closed;

  swc_spi_link u_link (
    .sck(spi_sck),
    .rstn(rstn),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .miso(spi_miso),
    .rx_word(rx_word),
    .rx_tgl(rx_tgl),
    .tx_word({8'h00, q.tx})
  );

  assign frame_ev = q.tsync[2] ^ q.tsync[1];
  assign f_addr = rx_word[31:25]; // R15
  assign f_wr = rx_word[24]; // R15
  assign f_data = rx_word[23:0]; // R15
  assign hiz = {q.gnd_hiz[13:0], q.prog_hiz[7:0]};
  assign wake_fall = q.wsync[2] & ~q.wsync[1];
  assign wake_ok = q.setup[SWC_BIT_WAKE_QUAL] | q.rsync[1]; // R3 R4
  assign plen = q.setup[SWC_BIT_POLL_SEL] ? PSHORT : PLONG; // R1

  // Closed switch reads one for either type
  always_comb begin
    for (int i = 0; i < 22; i++) begin
      if (i < 8 && q.setup[i]) begin
        sw_closed[i] = comp_above[i]; // R7
      end else begin
        sw_closed[i] = ~comp_above[i]; // R7 R9
      end
    end
  end

  always_comb begin
    case (f_addr)
      SWC_ADDR_SETUP: rd_data = q.setup & SWC_SETUP_MASK; // R16
      SWC_ADDR_PROG_HIZ: rd_data = q.prog_hiz & SWC_PROG_RST; // R10
      SWC_ADDR_GND_HIZ: rd_data = q.gnd_hiz & SWC_GND_RST; // R11
      default: rd_data = 24'h000000;
    endcase
  end

  always_comb begin
    d = q;
    d.tsync = {q.tsync[1:0], rx_tgl};
    d.wsync = {q.wsync[1:0], wake_n};
    d.rsync = {q.rsync[0], logic_supply_rail};
    d.ov = battery_overvoltage; // R2
    if (frame_ev) begin
      if (f_wr && !sleep_mode) begin
        unique case (f_addr)
          SWC_ADDR_SETUP: d.setup = f_data & SWC_SETUP_MASK; // R6 R16
          SWC_ADDR_PROG_HIZ: d.prog_hiz = f_data & SWC_PROG_RST; // R10 R14
          SWC_ADDR_GND_HIZ: d.gnd_hiz = f_data & SWC_GND_RST; // R11 R14
          default: d.setup = q.setup;
        endcase
      end
      d.tx = {fault_summary, ~irq_n, rd_data[21:0]}; // R15
    end
    // Poll cycle in sleep, judged at its end
    if (sleep_mode) begin
      if (q.pcnt >= plen) begin
        d.pcnt = '0;
        d.closed = sw_closed; // R13
        if (sw_closed != q.ref_state) begin
          d.wake = 1'b1; // R13
        end
        d.ref_state = sw_closed;
      end else begin
        d.pcnt = q.pcnt + 1'b1;
      end
    end else begin
      d.pcnt = '0;
      d.closed = sw_closed;
      d.ref_state = sw_closed;
      d.wake = 1'b0;
    end
    if (sleep_mode && wake_fall && wake_ok) begin
      d.wake = 1'b1; // R3 R4
    end
    d.pend = sleep_mode && (q.pcnt >= plen);
    // Latched until frame clears it, or a fixed pulse
    if (irq_event) begin
      d.irq_lat = 1'b1; // R5
      d.icnt = IPULSE;
    end else begin
      if (frame_ev) begin
        d.irq_lat = 1'b0;
      end
      if (q.icnt != 5'h00) begin
        d.icnt = q.icnt - 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.setup <= SWC_SETUP_RST; // R1 R6
      q.prog_hiz <= SWC_PROG_RST; // R10
      q.gnd_hiz <= SWC_GND_RST; // R11
      q.wsync <= 3'b111;
    end else begin
      q <= d;
    end
  end

  assign switch_to_battery = q.setup[7:0]; // R6
  assign battery_channel_poll_select = q.setup[SWC_BIT_POLL_SEL];
  assign current_cap = q.ov & ~q.setup[SWC_BIT_OV_OFF]; // R2
  assign sleep_block = q.ov & ~q.setup[SWC_BIT_OV_OFF]; // R2
  assign ov_flag = q.ov; // R2
  assign source_enable = ~hiz; // R8 R12
  assign poll_active = sleep_mode;
  assign poll_end = q.pend;
  assign closed_status = q.closed;
  assign wake_req = q.wake;
  assign irq_n = q.setup[SWC_BIT_IRQ_PULSE] ? (q.icnt == 5'h00) : ~q.irq_lat; // R5

  // Steps seen from the clk side: frames taken, poll ends
  sequence s_write_gnd;
    frame_ev && f_wr && !sleep_mode && f_addr == SWC_ADDR_GND_HIZ;
  endsequence
  sequence s_write_hiz;
    frame_ev && f_wr && !sleep_mode && f_addr == SWC_ADDR_PROG_HIZ;
  endsequence
  sequence s_write_setup;
    frame_ev && f_wr && !sleep_mode && f_addr == SWC_ADDR_SETUP;
  endsequence
  sequence s_sleep_write;
    frame_ev && f_wr && sleep_mode;
  endsequence
  sequence s_poll_end;
    sleep_mode && (q.pcnt >= plen);
  endsequence
  sequence s_state_change;
    sleep_mode && (q.pcnt >= plen) && (sw_closed != q.ref_state);
  endsequence

  // Register writes
  AST_HIZ_SRC: assert property (@(posedge clk) disable iff (!rstn) // R8
    s_write_gnd |=> source_enable[21:8] == ~$past(f_data[13:0]))
    else $error("hi-z input has source on");
  AST_WR_HIZ: assert property (@(posedge clk) disable iff (!rstn) // R14
    s_write_hiz |=> q.prog_hiz[7:0] == $past(f_data[7:0])) else $error("hi-z write lost");
  AST_SETUP_WR: assert property (@(posedge clk) disable iff (!rstn) // R6
    s_write_setup |=> switch_to_battery == $past(f_data[7:0]))
    else $error("input type write lost");
  AST_SLEEP_REFUSE: assert property (@(posedge clk) disable iff (!rstn) // R14
    s_sleep_write |=> $stable(q.setup) && $stable(q.prog_hiz) && $stable(q.gnd_hiz))
    else $error("write taken in sleep");
  AST_UNUSED: assert property (@(posedge clk) disable iff (!rstn) // R16
    (q.setup[23:14] == 10'h0) && (q.setup[9:8] == 2'b00)) else $error("unused bits set");
  AST_GNDHI: assert property (@(posedge clk) disable iff (!rstn) // R11
    q.gnd_hiz[23:14] == 10'h0) else $error("ground hi-z upper bits set");
  AST_PROGHI: assert property (@(posedge clk) disable iff (!rstn) // R10
    q.prog_hiz[23:8] == 16'h0) else $error("prog hi-z upper bits set");

  // Answer word captured at frame end
  AST_TX_CAP: assert property (@(posedge clk) disable iff (!rstn) // R15
    frame_ev |=> q.tx == {$past(fault_summary), ~$past(irq_n), $past(rd_data[21:0])})
    else $error("answer word wrong");
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rstn) // R15
    (frame_ev && f_addr != SWC_ADDR_SETUP && f_addr != SWC_ADDR_PROG_HIZ
     && f_addr != SWC_ADDR_GND_HIZ) |=> q.tx[21:0] == 22'h0)
    else $error("unmapped read not zero");

  // Overvoltage guard
  AST_CAP: assert property (@(posedge clk) disable iff (!rstn) // R2
    (battery_overvoltage && !q.setup[SWC_BIT_OV_OFF] && !frame_ev)
    |=> (current_cap && sleep_block)) else $error("overvoltage guard not applied");
  AST_NOCAP: assert property (@(posedge clk) disable iff (!rstn) // R2
    !battery_overvoltage |=> !current_cap && !sleep_block) else $error("guard without cause");
  AST_OVF: assert property (@(posedge clk) disable iff (!rstn) // R2
    battery_overvoltage |=> ov_flag) else $error("ov flag missing");

  // Poll timing and change of state
  AST_POLL_SHORT: assert property (@(posedge clk) disable iff (!rstn) // R1
    (sleep_mode && q.setup[SWC_BIT_POLL_SEL]) |-> q.pcnt <= PSHORT)
    else $error("short poll overrun");
  AST_POLL_LONG: assert property (@(posedge clk) disable iff (!rstn) // R1
    (sleep_mode && !q.setup[SWC_BIT_POLL_SEL]) |-> q.pcnt <= PLONG)
    else $error("long poll overrun");
  AST_POLL_END: assert property (@(posedge clk) disable iff (!rstn) // R13
    s_poll_end |=> poll_end) else $error("poll end missing");
  AST_COS_WAKE: assert property (@(posedge clk) disable iff (!rstn) // R13
    s_state_change |=> wake_req) else $error("change of state did not wake");
  AST_CLOSED_HOLD: assert property (@(posedge clk) disable iff (!rstn) // R13
    (sleep_mode && !(q.pcnt >= plen)) |=> $stable(closed_status))
    else $error("status moved inside poll");
  AST_GND_CLOSED: assert property (@(posedge clk) disable iff (!rstn) // R7 R9
    !sleep_mode |=> closed_status[21:8] == ~$past(comp_above[21:8]))
    else $error("ground input status wrong");
  AST_BAT_CLOSED: assert property (@(posedge clk) disable iff (!rstn) // R7
    (!sleep_mode && q.setup[0]) |=> closed_status[0] == $past(comp_above[0]))
    else $error("battery input status wrong");

  // Wake pin qualification
  AST_WAKE_IGN: assert property (@(posedge clk) disable iff (!rstn) // R3
    (sleep_mode && $past(sleep_mode) && !q.wake && wake_fall && !wake_ok
     && !(q.pcnt >= plen)) |=> !q.wake) else $error("wake while rail low");
  AST_WAKE_RAIL: assert property (@(posedge clk) disable iff (!rstn) // R3
    (sleep_mode && wake_fall && q.rsync[1]) |=> wake_req) else $error("wake with rail missed");
  AST_WAKE_EDGE: assert property (@(posedge clk) disable iff (!rstn) // R4
    (sleep_mode && wake_fall && q.setup[SWC_BIT_WAKE_QUAL]) |=> q.wake)
    else $error("wake edge missed");
  AST_WAKE_CLR: assert property (@(posedge clk) disable iff (!rstn) // R13
    !sleep_mode |=> !wake_req) else $error("wake held outside sleep");

  // Interrupt pin style
  AST_PULSE: assert property (@(posedge clk) disable iff (!rstn) // R5
    (q.setup[SWC_BIT_IRQ_PULSE] && irq_event) |=> !irq_n)
    else $error("irq pulse missing");
  AST_PULSE_END: assert property (@(posedge clk) disable iff (!rstn) // R5
    (q.setup[SWC_BIT_IRQ_PULSE] && q.icnt == 5'h01 && !irq_event && !frame_ev) |=> irq_n)
    else $error("irq pulse not released");
  AST_IRQ_HOLD: assert property (@(posedge clk) disable iff (!rstn) // R5
    (!q.setup[SWC_BIT_IRQ_PULSE] && !irq_n && !frame_ev) |=> !irq_n)
    else $error("latched irq released");
  AST_IRQ_WINS: assert property (@(posedge clk) disable iff (!rstn) // R5
    (irq_event && frame_ev) |=> q.irq_lat) else $error("irq lost to clear");
endmodule : swc_cfg_regs

// ===== rtl/swc_pkg.sv
// Constants, register map and field layout of the switch input configuration bank.
// Assumes a 32-bit SPI frame: address 31..25, write bit 24, data 23..0.
// Overview of operation
// R1: Bit 13 picks battery-channel active poll time.
// R2: Overvoltage with guard on caps current, blocks sleep.
// R3: Qualify off: ignore wake pin when rail low.
// R4: Qualify on: any wake falling edge wakes.
// R5: Bit 10 selects latched or pulsed interrupt.
// R6: Bits 7..0 set input battery/ground type.
// R7: Closed programmable input reports logic one.
// R8: Hi-z bit disables that input's current source.
// R9: Comparator keeps running while input hi-z.
// R10: Programmable hi-z register, eight bits, reset ones.
// R11: Ground hi-z register, fourteen bits, reset ones.
// R12: Sleep polls hi-z inputs without current.
// R13: Change of state judged at poll end.
// R14: Hi-z registers writable any time in normal.
// R15: Frame layout; answer carries fault, irq, data.
// R16: Unused setup bits read zero, ignore writes.
package swc_pkg;
  localparam int unsigned SWC_FRAME_W = 32;
  localparam int unsigned SWC_DATA_W = 24;
  localparam int unsigned SWC_ADDR_W = 7;
  localparam int unsigned SWC_NPROG = 8;
  localparam int unsigned SWC_NGND = 14;
  localparam logic [6:0] SWC_ADDR_SETUP = 7'h01;
  localparam logic [6:0] SWC_ADDR_PROG_HIZ = 7'h02;
  localparam logic [6:0] SWC_ADDR_GND_HIZ = 7'h03;
  localparam int unsigned SWC_BIT_POLL_SEL = 13;
  localparam int unsigned SWC_BIT_OV_OFF = 12;
  localparam int unsigned SWC_BIT_WAKE_QUAL = 11;
  localparam int unsigned SWC_BIT_IRQ_PULSE = 10;
  localparam int unsigned SWC_BIT_FAULT = 23;
  localparam int unsigned SWC_BIT_IRQ = 22;
  localparam logic [23:0] SWC_SETUP_MASK = 24'h003CFF;
  localparam logic [23:0] SWC_SETUP_RST = 24'h0008FF;
  localparam logic [23:0] SWC_PROG_RST = 24'h0000FF;
  localparam logic [23:0] SWC_GND_RST = 24'h003FFF;
  localparam int unsigned SWC_CLK_MHZ = 200;
  localparam int unsigned SWC_POLL_LONG_US = 1000;
  localparam int unsigned SWC_POLL_SHORT_NS = 55000;
  localparam int unsigned SWC_POLL_LONG_CYC = SWC_POLL_LONG_US * SWC_CLK_MHZ;
  localparam int unsigned SWC_POLL_SHORT_CYC = SWC_POLL_SHORT_NS * SWC_CLK_MHZ / 1000;
  localparam int unsigned SWC_IRQ_PULSE_NS = 100;
  localparam int unsigned SWC_IRQ_PULSE_CYC = SWC_IRQ_PULSE_NS * SWC_CLK_MHZ / 1000;
  localparam int unsigned SWC_CAP_CODE = 0;
endpackage : swc_pkg

// ===== rtl/swc_spi_link.sv
// SPI slave shifter on the serial clock; hands whole frames to clk domain by toggle.
// Assumes mode 0: sample on rising sck, shift out on falling, cs_n frames a word.
`timescale 1ns/1ps
module swc_spi_link
  import swc_pkg::*;
(
  input wire logic sck,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic [31:0] rx_word,
  output logic rx_tgl,
  input wire logic [31:0] tx_word
);
  typedef struct packed {
    logic [31:0] sh;
    logic [5:0] cnt;
  } swc_in_t;
  swc_in_t s_q, s_d;
  logic [31:0] rx_q, rx_d;
  logic tgl_q, tgl_d;
  logic [31:0] out_q;
  logic [5:0] ocnt_q;

  always_comb begin
    s_d = s_q;
    rx_d = rx_q;
    tgl_d = tgl_q;
    s_d.sh = {s_q.sh[30:0], mosi};
    s_d.cnt = s_q.cnt + 6'h01;
    if (s_q.cnt == 6'h1F) begin
      rx_d = {s_q.sh[30:0], mosi};
      tgl_d = ~tgl_q;
      s_d.cnt = 6'h00;
    end
  end

  // Bit counter restarts with each frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Word and toggle outlive the frame; a known toggle start keeps the far side in step
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      rx_q <= 32'h0;
      tgl_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      tgl_q <= tgl_d;
    end
  end

  // Answer word loaded at frame start, MSB first
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      out_q <= 32'h0;
      ocnt_q <= 6'h00;
    end else begin
      ocnt_q <= ocnt_q + 6'h01;
      out_q <= (ocnt_q == 6'h00) ? {tx_word[30:0], 1'b0} : {out_q[30:0], 1'b0};
    end
  end

  assign miso = (ocnt_q == 6'h00) ? tx_word[31] : out_q[31];
  assign rx_word = rx_q;
  assign rx_tgl = tgl_q;
endmodule : swc_spi_link

// ===== verification/swc_host_model.sv
// Host-side SPI master model: mode 0 frames, MSB first, 48 ns serial clock.
// Assumes the slave shifts out on falling sck and takes mosi on rising sck.
`timescale 1ns/1ps
module swc_host_model (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Clock stands still between frames; mosi flips once released
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi = w[i];
      #24 sck = 1'b1;
      r[i] = miso;
      #24 sck = 1'b0;
    end
    #24 cs_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask : xfer
endmodule : swc_host_model

// ===== verification/tb_top.sv
// Self-checking bench of the configuration bank: random and corner traffic.
// Assumes swc_host_model drives the serial link of the bank.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top
  import swc_pkg::*;
;
  logic clk, rstn, sck, cs_n, mosi, miso, fs, irq_ev, ov, slp, rail, wake_n;
  logic cap, blk, ovf, wake_req, irq_n, psel;
  logic [21:0] comp, closed, src_en;
  logic [7:0] stb;
  logic [23:0] m [128];
  logic [31:0] r;
  int err_count = 0;
  int compares = 0;
  int seed;

  swc_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  swc_cfg_regs #(.POLL_LONG_CYC(20), .POLL_SHORT_CYC(8)) uut (
    .clk(clk), .rstn(rstn), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .fault_summary(fs), .irq_event(irq_ev), .battery_overvoltage(ov),
    .sleep_mode(slp), .logic_supply_rail(rail), .wake_n(wake_n), .comp_above(comp),
    .closed_status(closed), .source_enable(src_en), .switch_to_battery(stb),
    .current_cap(cap), .sleep_block(blk), .ov_flag(ovf), .wake_req(wake_req),
    .irq_n(irq_n), .battery_channel_poll_select(psel), .poll_active(), .poll_end());

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [23:0] msk(input logic [6:0] a);
    case (a)
      SWC_ADDR_SETUP: return SWC_SETUP_MASK;
      SWC_ADDR_PROG_HIZ: return 24'h0000FF;
      SWC_ADDR_GND_HIZ: return 24'h003FFF;
      default: return 24'h000000;
    endcase
  endfunction : msk

  function automatic logic [21:0] cls(input logic [21:0] c, input logic [7:0] t);
    for (int i = 0; i < 22; i++) begin
      cls[i] = (i < 8 && t[i]) ? c[i] : ~c[i];
    end
  endfunction : cls

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic fr(input logic [31:0] w);
    host.xfer(w, r);
    cyc(1);
  endtask : fr

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    fr({a, 1'b1, d});
    if (!slp) m[a] = d & msk(a);
  endtask : wr

  task automatic rd(input logic [6:0] a);
    fr({a, 1'b0, 24'h000000});
    fr({a, 1'b0, 24'h000000});
    `CHK(r[23:0], {fs, 1'b0, m[a][21:0]})
  endtask : rd

  task automatic results;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial begin
    #400000;
    err_count++;
    results();
  end

  initial begin
    seed = $urandom(85013);
    {rstn, irq_ev, ov, slp, rail, wake_n} = 6'b000001;
    fs = 1'($urandom);
    comp = 22'h000000;
    m = '{default: 24'h000000};
    m[1] = SWC_SETUP_RST;
    m[2] = SWC_PROG_RST;
    m[3] = SWC_GND_RST;
    cyc(16);
    rstn = 1'b1;
    cyc(4);
    `CHK(src_en, 22'h000000)
    `CHK(stb, 8'hFF)
    for (int a = 1; a < 5; a++) rd(a[6:0]);
    for (int k = 0; k < 16; k++) begin
      wr(7'(k % 4 + 1), k < 4 ? 24'hFFFFFF : 24'($urandom));
      comp = 22'($urandom);
      rd(7'(k % 4 + 1));
      `CHK(src_en, ~{m[3][13:0], m[2][7:0]})
      `CHK(stb, m[1][7:0])
      `CHK(psel, m[1][13])
      `CHK(closed, cls(comp, m[1][7:0]))
    end
    wr(7'h01, 24'h000000);
    ov = 1'b1;
    cyc(3);
    `CHK({cap, blk, ovf}, 3'b111)
    wr(7'h01, 24'h001000);
    `CHK({cap, blk, ovf}, 3'b001)
    ov = 1'b0;
    wr(7'h01, 24'h000000);
    irq_ev = 1'b1;
    cyc(1);
    irq_ev = 1'b0;
    cyc(30);
    `CHK(irq_n, 1'b0)
    fr({7'h01, 1'b0, 24'h000000});
    `CHK(irq_n, 1'b1)
    wr(7'h01, 24'h000400);
    irq_ev = 1'b1;
    cyc(1);
    irq_ev = 1'b0;
    cyc(SWC_IRQ_PULSE_CYC - 1);
    `CHK(irq_n, 1'b0)
    cyc(1);
    `CHK(irq_n, 1'b1)
    for (int q = 2; q >= 0; q--) begin
      rail = q[1];
      wr(7'h01, {12'h000, q[0], 11'h000});
      slp = 1'b1;
      wr(7'h02, 24'($urandom));
      rd(7'h02);
      wake_n = 1'b0;
      cyc(10);
      `CHK(wake_req, q[0] | q[1])
      `CHK(src_en, ~{m[3][13:0], m[2][7:0]})
      slp = 1'b0;
      wake_n = 1'b1;
      cyc(10);
    end
    wr(7'h01, 24'h002000);
    slp = 1'b1;
    cyc(3);
    `CHK(wake_req, 1'b0)
    comp = ~comp;
    cyc(12);
    `CHK(wake_req, 1'b1)
    `CHK(closed, cls(comp, m[1][7:0]))
    slp = 1'b0;
    cyc(2);
    results();
  end
endmodule : tb_top
